// *** pmc_checker.sv ***
/*
 assertions on the mode outputs of the power mode controller.
 bound to pmc_power_mode_control; sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module pmc_checker (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        cyc_i,
  input wire logic        irq_pending_i,
  input wire logic        any_reset_i,
  input wire logic        cpu_clk_en_o,
  input wire logic        periph_clk_en_o,
  input wire logic        sys_clk_en_o,
  input wire logic        precision_osc_en_o,
  input wire logic        int_osc_en_o,
  input wire logic        core_supply_en_o,
  input wire logic        rtc_osc_en_o,
  input wire logic        restart_o,
  input wire logic [15:0] restart_addr_o,
  input wire logic        wake_irq_o,
  input wire logic [2:0]  mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  wire quiet = !any_reset_i && !cyc_i;
  norm_ungated_a: assert property (mode_o == 3'h0 |-> cpu_clk_en_o && sys_clk_en_o && core_supply_en_o)
    else $error("normal mode has gating");
  idle_clk_a: assert property (mode_o == 3'h1 |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle clock enables wrong");
  idle_wake_a: assert property (mode_o == 3'h1 && irq_pending_i && quiet |=> mode_o == 3'h0)
    else $error("interrupt did not end idle");
  idle_hold_a: assert property (mode_o == 3'h1 && !irq_pending_i && quiet |=> $stable(mode_o))
    else $error("idle left without cause");
  // stop must ignore interrupts; only a reset may end it
  stop_hold_a: assert property (mode_o == 3'h2 && quiet |=> mode_o == 3'h2)
    else $error("stop left without reset");
  stop_osc_a: assert property (mode_o == 3'h2 |-> !precision_osc_en_o && !cpu_clk_en_o)
    else $error("stop oscillator running");
  susp_gate_a: assert property (mode_o == 3'h3 |-> !sys_clk_en_o && !int_osc_en_o)
    else $error("suspend clock not gated");
  sleep_gate_a: assert property (mode_o == 3'h4 |-> !core_supply_en_o && rtc_osc_en_o)
    else $error("sleep supply not gated");
  reset_mode_a: assert property (any_reset_i |=> mode_o == 3'h0)
    else $error("reset did not restore normal");
  restart_vec_a: assert property ($fell(any_reset_i) |-> ##[0:1] restart_o && restart_addr_o == 16'h0000)
    else $error("no restart at address zero");
  wake_irq_a: assert property (wake_irq_o == (mode_o == 3'h1 && irq_pending_i))
    else $error("wake interrupt flag wrong");
  cover property (mode_o == 3'h1);
  cover property (mode_o == 3'h2);
  cover property (mode_o == 3'h3);
  cover property (mode_o == 3'h4);
endmodule : pmc_checker
bind pmc_power_mode_control pmc_checker i_chk (.clk_sys_i, .rst_b_i, .cyc_i, .irq_pending_i, .any_reset_i,
  .cpu_clk_en_o, .periph_clk_en_o, .sys_clk_en_o, .precision_osc_en_o, .int_osc_en_o, .core_supply_en_o,
  .rtc_osc_en_o, .restart_o, .restart_addr_o, .wake_irq_o, .mode_o);
`default_nettype wire

// *** pmc_pkg.sv ***
/*
 power mode control package: register offsets, field positions, reset values,
 power mode enumeration and timing constants.
 assumes a 250 MHz system clock and a 32-bit classic wishbone register bus.
*/
package pmc_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned REG_W            = 8;
  // register offsets are word indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] SCALE_IDX  = 8'hb6;
  localparam logic [ADDR_W-1:0] PCTRL_IDX  = 8'h87;
  localparam logic [ADDR_W-1:0] PMCFG_IDX  = 8'hb3;
  localparam logic [ADDR_W-1:0] STAT_IDX   = 8'hb4;
  localparam int unsigned IDLE_BIT         = 0;
  localparam int unsigned STOP_BIT         = 1;
  localparam int unsigned BYPASS_BIT       = 6;
  localparam int unsigned SUSP_BIT         = 6;
  localparam int unsigned SLEEP_BIT        = 7;
  localparam logic [REG_W-1:0] PCTRL_MASK  = 8'h03;
  localparam logic [REG_W-1:0] SCALE_MASK  = 8'h40;
  localparam logic [REG_W-1:0] PMCFG_MASK  = 8'hc0;
  localparam logic [REG_W-1:0] RESET_VAL   = 8'h00;
  localparam logic [15:0]      RESET_VECTOR = 16'h0000;
  // flash one-shot read pulse length in ns
  localparam int unsigned ONESHOT_NS       = 40;
  localparam int unsigned ONESHOT_CYC      = (ONESHOT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OS_CNT_W         = 4;
  localparam logic [OS_CNT_W-1:0] OS_CNT_LD = OS_CNT_W'(ONESHOT_CYC);
  // wake-up source index in the wake vector
  localparam int unsigned WK_RTC           = 0;
  localparam int unsigned WK_PORT          = 1;
  localparam int unsigned WK_CMP0          = 2;
  localparam int unsigned WK_RSTPIN        = 3;
  localparam int unsigned WK_N             = 4;

  typedef enum logic [2:0] {
    PMC_NORMAL,
    PMC_IDLE,
    PMC_STOP,
    PMC_SUSPEND,
    PMC_SLEEP
  } pmc_mode_e;
endpackage : pmc_pkg

// *** pmc_power_mode_control.sv ***
/*
 power mode controller: selects normal, idle, stop, suspend and sleep, gates the
 processor clock, system clock and core supply, and holds the flash scale register.
 assumes a classic wishbone master, an interrupt controller that reports an
 enabled pending interrupt, a processor that flags instruction completion, and
 a reset generator that reports any reset, including the watchdog one.
*/
// What this block does
// RQ1: five power modes, entry and wake handled
// RQ2: idle bit halts fetch after instruction ends
// RQ3: idle keeps state, peripherals keep running
// RQ4: idle ends only on interrupt or reset
// RQ5: interrupt wake clears idle bit in hardware
// RQ6: wake services interrupt, resumes next instruction
// RQ7: reset wake restarts from address zero
// RQ8: enabled watchdog reset ends idle
// RQ9: software may disable watchdog before idle
// RQ10: software should enable one-shot before idle
// RQ11: bypass zero, one-shot times flash read
// RQ12: bypass one, system clock times flash read
// RQ13: reserved scale bits written zero, read zero
// RQ14: stop halts code, oscillator, reset wakes
// RQ15: suspend gates clock, listed sources wake
// RQ16: sleep gates supply, same wake sources
// RQ17: stop bit enters stop after instruction
// RQ18: suspend bit gates clock, stops oscillators
// RQ19: idle gates cpu clock, peripherals still clocked
// RQ20: normal mode gates nothing
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_control
  import pmc_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  // classic wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W+1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output var  logic [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  output logic                   err_o,
  // processor and system side
  input  wire logic              instr_done_i,
  input  wire logic              irq_pending_i,
  input  wire logic              any_reset_i,
  input  wire logic [WK_N-1:0]   wake_src_i,
  input  wire logic              flash_rd_start_i,
  output var  logic              cpu_clk_en_o,
  output var  logic              periph_clk_en_o,
  output var  logic              sys_clk_en_o,
  output var  logic              precision_osc_en_o,
  output var  logic              int_osc_en_o,
  output var  logic              core_supply_en_o,
  output var  logic              rtc_osc_en_o,
  output var  logic              restart_o,
  output var  logic [15:0]       restart_addr_o,
  output var  logic              wake_irq_o,
  output var  logic              flash_rd_active_o,
  output var  logic [2:0]        mode_o
);

  pmc_mode_e               mode;
  pmc_mode_e               next_mode;
  pmc_mode_e               mode_d;
  logic [REG_W-1:0]        pctrl;
  logic [REG_W-1:0]        scale_reg;
  logic [REG_W-1:0]        pmcfg;
  logic [WK_N-1:0]         wake_flags;
  logic [WK_N-1:0]         next_wake_flags;
  logic [WK_N-1:0]         wake_sync;
  logic                    ack_q;
  logic [OS_CNT_W-1:0]     os_cnt;
  logic [OS_CNT_W-1:0]     next_os_cnt;
  logic                    rst_seen;

  // external wake sources are asynchronous pins or other-domain events
  pmc_sync2 #(
    .W (WK_N)
  ) u_wake_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (wake_src_i),
    .sync_o    (wake_sync)
  );

  // any reset source puts the mode and the mode selects back to reset state
  wire                    soft_rst  = !rst_b_i || any_reset_i;

  // views of the mode register
  wire                    in_idle   = mode == PMC_IDLE;
  wire                    in_susp   = mode == PMC_SUSPEND;
  wire                    in_sleep  = mode == PMC_SLEEP;
  wire                    in_lp     = in_susp | in_sleep;

  // bus decode
  wire                    req       = cyc_i & stb_i;
  wire [ADDR_W-1:0]       idx       = adr_i[ADDR_W+1:2];
  wire                    hit_pctrl = idx == PCTRL_IDX;
  wire                    hit_scale = idx == SCALE_IDX;
  wire                    hit_pmcfg = idx == PMCFG_IDX;
  wire                    hit_stat  = idx == STAT_IDX;
  wire                    hit_any   = hit_pctrl | hit_scale | hit_pmcfg | hit_stat;
  // a held request is taken once: nothing is stored while the answer is out
  wire                    wr_lane   = req & we_i & sel_i[0] & ~ack_q;
  wire                    wr_pctrl  = wr_lane & hit_pctrl;
  wire                    wr_scale  = wr_lane & hit_scale;
  wire                    wr_pmcfg  = wr_lane & hit_pmcfg;
  wire                    wr_stat   = wr_lane & hit_stat;
  wire [REG_W-1:0]        wdat      = dat_i[REG_W-1:0];

  // unused and reserved bits are dropped on write, so they always read zero
  wire [REG_W-1:0]        sw_pctrl  = wdat & PCTRL_MASK;
  wire [REG_W-1:0]        sw_pmcfg  = wdat & PMCFG_MASK;
  // RQ13: reserved bits forced zero
  wire [REG_W-1:0]        sw_scale  = wdat & SCALE_MASK;

  // mode request decode
  wire                    idle_req  = pctrl[IDLE_BIT];
  wire                    stop_req  = pctrl[STOP_BIT];
  wire                    susp_req  = pmcfg[SUSP_BIT];
  wire                    sleep_req = pmcfg[SLEEP_BIT];
  wire                    wake_lp   = |wake_sync;
  // stop outranks idle when software sets both in one write
  wire                    enter_stop = instr_done_i & stop_req;
  wire                    enter_idle = instr_done_i & idle_req & ~stop_req;

  // read path; unmapped indices read zero and are answered with err
  wire [REG_W-1:0]        stat_word = {wake_flags, 1'b0, mode};
  wire [REG_W-1:0]        rd_mux    =
      hit_pctrl ? pctrl :
      hit_scale ? scale_reg :
      hit_pmcfg ? pmcfg :
      hit_stat  ? stat_word : RESET_VAL;
  wire                    next_ack  = req & hit_any & ~ack_q;
  wire                    next_err  = req & ~hit_any & ~ack_q & ~err_o;
  wire [DATA_W-1:0]       next_dat  = {{(DATA_W-REG_W){1'b0}}, rd_mux};

  // answer one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= next_ack;
    end
  end
  assign ack_o = ack_q;

  // err stands one cycle and is never followed at once by a second err; an ack may follow it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      err_o <= 1'b0;
    end else begin
      err_o <= next_err;
    end
  end

  // read data is registered with ack, so the master takes it at the ack edge
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      dat_o <= '0;
    end else begin
      dat_o <= next_dat;
    end
  end

  // mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      PMC_NORMAL: begin
        // RQ2: idle after instruction completes
        // RQ17: stop after instruction completes
        if (enter_stop)                     next_mode = PMC_STOP;
        else if (enter_idle)                next_mode = PMC_IDLE;
        // RQ18: suspend select gates clock
        // RQ16: sleep select gates supply
        else if (sleep_req)                 next_mode = PMC_SLEEP;
        else if (susp_req)                  next_mode = PMC_SUSPEND;
      end
      PMC_IDLE: begin
        // RQ4: only interrupt or reset ends idle
        if (irq_pending_i)                  next_mode = PMC_NORMAL;
      end
      PMC_STOP: begin
        // RQ14: nothing but reset leaves stop
        next_mode = PMC_STOP;
      end
      PMC_SUSPEND, PMC_SLEEP: begin
        // RQ15: listed sources wake suspend
        if (wake_lp)                        next_mode = PMC_NORMAL;
      end
      default:                              next_mode = PMC_NORMAL;
    endcase
  end

  // RQ7: reset returns to normal
  // RQ8: watchdog reset arrives here
  assign mode_d = soft_rst ? PMC_NORMAL : next_mode;

  // limitation: interrupts are ignored in stop; software must rely on a reset
  always_ff @(posedge clk_sys_i) begin
    mode <= mode_d;
  end

  // hardware clears of the mode bits win over a software write in one cycle
  wire                    idle_hw_clr = in_idle & irq_pending_i;
  wire                    lp_hw_clr   = in_lp & wake_lp;

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      pctrl <= RESET_VAL;
    end else if (idle_hw_clr) begin
      // RQ5: interrupt clears idle bit
      pctrl[IDLE_BIT] <= 1'b0;
    end else if (wr_pctrl) begin
      pctrl <= sw_pctrl;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      pmcfg <= RESET_VAL;
    end else if (lp_hw_clr) begin
      pmcfg[SUSP_BIT]  <= 1'b0;
      pmcfg[SLEEP_BIT] <= 1'b0;
    end else if (wr_pmcfg) begin
      pmcfg <= sw_pmcfg;
    end
  end

  // the scale register survives internal resets; only the reset pin clears it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      scale_reg <= RESET_VAL;
    end else if (wr_scale) begin
      scale_reg <= sw_scale;
    end
  end

  // sticky wake source flags: a new wake wins over a software clear
  // flags survive internal resets so software can still see why it woke
  wire [WK_N-1:0]         flag_clr  = wr_stat ? wdat[REG_W-1:REG_W-WK_N] : '0;
  // RQ15: listed sources record a flag
  wire [WK_N-1:0]         flag_set  = in_lp ? wake_sync : '0;
  assign next_wake_flags = (wake_flags & ~flag_clr) | flag_set;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      wake_flags <= '0;
    end else begin
      wake_flags <= next_wake_flags;
    end
  end

  // flash read timing
  // limitation: a start while the one-shot runs restarts the pulse
  wire                    bypass    = scale_reg[BYPASS_BIT];
  wire                    os_busy   = os_cnt != '0;
  wire                    os_load   = flash_rd_start_i & ~bypass;
  // RQ11: one-shot sets read time
  assign next_os_cnt = os_load ? OS_CNT_LD : (os_busy ? os_cnt - 1'b1 : os_cnt);
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      os_cnt <= '0;
    end else begin
      os_cnt <= next_os_cnt;
    end
  end
  // RQ12: bypass follows the system clock
  assign flash_rd_active_o = bypass ? flash_rd_start_i : os_busy;

  // reset restart strobe: one cycle after a reset ends; the seen flag starts
  // set so that the release of the reset pin restarts the processor as well
  wire                    reset_ended = rst_seen & ~any_reset_i;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rst_seen <= 1'b1;
    end else begin
      rst_seen <= any_reset_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      restart_o <= 1'b0;
    end else begin
      restart_o <= reset_ended;
    end
  end
  // RQ7: restart from address zero
  assign restart_addr_o = RESET_VECTOR;

  // RQ6: interrupt wake, cpu resumes next instruction
  assign wake_irq_o = in_idle & irq_pending_i;

  // clock and supply controls come from flip-flops, rtc_osc_en_o is tied high, so the gates see no glitch;
  // they are loaded from the next mode, so they change together with mode
  // RQ19: idle gates only the cpu clock
  // RQ3: peripherals and state retained in idle
  // RQ20: normal gates nothing
  wire                    next_cpu_clk_en = mode_d == PMC_NORMAL;
  wire                    next_periph_en  = mode_d == PMC_NORMAL || mode_d == PMC_IDLE;
  // RQ15: suspend gates system clock
  wire                    next_sys_clk_en = mode_d != PMC_SUSPEND && mode_d != PMC_SLEEP;
  // RQ16: sleep gates supply, keeps rtc
  wire                    next_supply_en  = mode_d != PMC_SLEEP;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cpu_clk_en_o    <= 1'b1;
      periph_clk_en_o <= 1'b1;
      sys_clk_en_o    <= 1'b1;
    end else begin
      cpu_clk_en_o    <= next_cpu_clk_en;
      periph_clk_en_o <= next_periph_en;
      sys_clk_en_o    <= next_sys_clk_en;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      precision_osc_en_o <= 1'b1;
      int_osc_en_o       <= 1'b1;
    end else begin
      // RQ14: stop disables precision oscillator
      precision_osc_en_o <= next_periph_en;
      // RQ18: internal oscillators off in suspend
      int_osc_en_o       <= next_sys_clk_en;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      core_supply_en_o <= 1'b1;
    end else begin
      core_supply_en_o <= next_supply_en;
    end
  end
  assign rtc_osc_en_o       = 1'b1;
  // RQ1: current mode visible
  assign mode_o             = mode;

endmodule : pmc_power_mode_control
`default_nettype wire

// *** pmc_sync2.sv ***
/*
 two flip-flop synchroniser for W levels from outside the clock domain.
 assumes one system clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pmc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : pmc_sync2
`default_nettype wire

// *** tb_power_mode_control.sv ***
/*
 self-checking bench for the power mode controller.
 drives wishbone and the processor side directly; one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_power_mode_control;
  import pmc_pkg::*;
  logic clk_sys_i, rst_b_i, cyc_i, stb_i, we_i, ack_o, err_o, instr_done_i, irq_pending_i, any_reset_i;
  logic flash_rd_start_i, cpu_clk_en_o, periph_clk_en_o, sys_clk_en_o, precision_osc_en_o, int_osc_en_o;
  logic core_supply_en_o, rtc_osc_en_o, restart_o, wake_irq_o, flash_rd_active_o;
  logic [ADDR_W+1:0] adr_i;
  logic [3:0]        sel_i;
  logic [DATA_W-1:0] dat_i, dat_o;
  logic [WK_N-1:0]   wake_src_i;
  logic [15:0]       restart_addr_o;
  logic [2:0]        mode_o;
  int                err_count = 0;
  int                checks_done = 0;
  pmc_power_mode_control i_dut (.clk_sys_i, .rst_b_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .instr_done_i, .irq_pending_i, .any_reset_i, .wake_src_i, .flash_rd_start_i, .cpu_clk_en_o,
    .periph_clk_en_o, .sys_clk_en_o, .precision_osc_en_o, .int_osc_en_o, .core_supply_en_o, .rtc_osc_en_o,
    .restart_o, .restart_addr_o, .wake_irq_o, .flash_rd_active_o, .mode_o);
  task automatic end_of_test();
    $display("checks_done %0d err_count %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  // values read after an edge are those the edge sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
                    output logic e);
    int t = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    do begin
      tick(1);
      t++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && t < 50);
    q = dat_o;
    e = err_o;
    if (t >= 50) err_count++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    tick(1);
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wb(1'b1, idx, d, q, e);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] idx, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    wb(1'b0, idx, 32'h0, q, e);
    chk(n, x, q);
  endtask : rd
  task automatic pulse_done();
    instr_done_i <= 1'b1;
    tick(1);
    instr_done_i <= 1'b0;
    tick(1);
  endtask : pulse_done
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd("scale_rst", SCALE_IDX, 32'h0);
    wr(SCALE_IDX, 32'hff);
    rd("scale_rsvd", SCALE_IDX, 32'h40);
    wb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped_err", 32'h1, 32'(e));
  endtask : t_regs
  task automatic t_flash();
    int n = 0;
    flash_rd_start_i <= 1'b1;
    tick(1);
    flash_rd_start_i <= 1'b0;
    chk("bypass_rd", 32'h1, 32'(flash_rd_active_o));
    wr(SCALE_IDX, 32'h0);
    flash_rd_start_i <= 1'b1;
    repeat (20) begin
      tick(1);
      flash_rd_start_i <= 1'b0;
      if (flash_rd_active_o === 1'b1) n++;
    end
    chk("one_shot_len", ONESHOT_CYC, n);
  endtask : t_flash
  task automatic t_idle();
    wr(PCTRL_IDX, 32'h1);
    tick(2);
    chk("idle_wait", PMC_NORMAL, mode_o);
    pulse_done();
    chk("idle_mode", PMC_IDLE, mode_o);
    chk("idle_periph", 32'h1, 32'(periph_clk_en_o));
    tick(20);
    chk("idle_stays", PMC_IDLE, mode_o);
    irq_pending_i <= 1'b1;
    tick(1);
    chk("wake_irq", 32'h1, 32'(wake_irq_o));
    irq_pending_i <= 1'b0;
    tick(2);
    chk("irq_exit", PMC_NORMAL, mode_o);
    rd("idle_bit_clr", PCTRL_IDX, 32'h0);
  endtask : t_idle
  // stop and idle both end on reset; stop also ignores an interrupt
  task automatic t_rst(input logic [31:0] pc, input pmc_mode_e m);
    int n = 0;
    wr(PCTRL_IDX, pc);
    pulse_done();
    chk("lp_mode", m, mode_o);
    irq_pending_i <= (m == PMC_STOP);
    tick(3);
    chk("lp_hold", m, mode_o);
    irq_pending_i <= 1'b0;
    any_reset_i <= 1'b1;
    tick(1);
    any_reset_i <= 1'b0;
    repeat (4) begin
      tick(1);
      if (restart_o === 1'b1) n++;
    end
    chk("restart_pulse", 32'h1, n);
    chk("rst_exit", PMC_NORMAL, mode_o);
    rd("pctrl_rst", PCTRL_IDX, 32'h0);
  endtask : t_rst
  task automatic t_lp();
    int n;
    for (int k = 0; k < WK_N; k++) begin
      wr(PMCFG_IDX, k[0] ? 32'h80 : 32'h40);
      tick(1);
      chk("lp_enter", k[0] ? PMC_SLEEP : PMC_SUSPEND, mode_o);
      chk("sys_clk", 32'h0, 32'(sys_clk_en_o));
      chk("supply", 32'(!k[0]), 32'(core_supply_en_o));
      wake_src_i <= 4'h1 << k;
      n = 0;
      while (mode_o !== PMC_NORMAL && n < 10) begin
        tick(1);
        n++;
      end
      wake_src_i <= 4'h0;
      chk("lp_wake", 32'h1, 32'(n < 10));
      rd("wake_flag", STAT_IDX, 32'h10 << k);
      wr(STAT_IDX, 32'hf0);
    end
  endtask : t_lp
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {rst_b_i, cyc_i, stb_i, we_i, instr_done_i, irq_pending_i, any_reset_i, flash_rd_start_i} = 8'h00;
    adr_i = '0;
    dat_i = '0;
    wake_src_i = '0;
    sel_i = 4'h1;
    tick(12);
    rst_b_i <= 1'b1;
    tick(2);
    t_regs();
    t_flash();
    t_idle();
    t_rst(32'h1, PMC_IDLE);
    t_rst(32'h3, PMC_STOP);
    t_lp();
    end_of_test();
  end
  initial begin
    #40000;
    err_count++;
    end_of_test();
  end
endmodule : tb_power_mode_control
`default_nettype wire
